// File: hw/sync_power_event_status.v
// Event status registers for converter alignment and converter-1 power events.
// How it works
// - With latch mode low, reading a bit returns the live condition, unstored.
// - With latch mode high, a rising edge sets the bit and pulls interrupt low.
// - Writing one to a latched bit clears it; writing zero leaves it.
// - Converter-0 alignment status bit 3 reports alignment locked.
// - Converter-0 alignment status bit 2 reports alignment rotated.
// - Converter-0 alignment status bit 1 reports phase outside window.
// - Converter-0 alignment status bit 0 reports alignment tripped.
// - Status 0x026 bit 7 reports converter-1 power over threshold, own latch mode.
// - Status 0x026 bit 5 reports converter-1 blanking complete.
`timescale 1ns/100ps
`include "sync_power_event_map.vh"
module sync_power_event_status
(
   // Clock and reset.
   input  wire       ref_clk,
   input  wire       rst,
   // Register access from the serial control port.
   input  wire [7:0] regAddr,
   input  wire       regWrite,
   input  wire [7:0] regWdata,
   input  wire       regRead,
   output reg  [7:0] regRdata_q,
   // Event conditions.
   input  wire       conv0_align_locked,
   input  wire       conv0_align_rotated,
   input  wire       conv0_phase_out_of_window,
   input  wire       conv0_align_tripped,
   input  wire       conv1_power_over_threshold,
   input  wire       conv1_blanking_complete,
   // Latch-mode controls.
   input  wire       latch_mode_conv0_locked,
   input  wire       latch_mode_conv0_rotated,
   input  wire       latch_mode_conv0_window,
   input  wire       latch_mode_conv0_tripped,
   input  wire       latch_mode_conv1_power,
   input  wire       latch_mode_conv1_blanking,
   // Interrupt, active low.
   output reg        irqN_q
);

   wire [5:0] cond;
   wire [5:0] mode;
   wire [5:0] clr;
   wire [5:0] stat;
   wire [5:0] held;
   wire       wrConv0;
   wire       wrConv1;
   wire [7:0] conv0Word;
   wire [7:0] conv1Word;
   reg  [7:0] rdata_d;

   assign cond = {conv1_blanking_complete, conv1_power_over_threshold,
                  conv0_align_locked, conv0_align_rotated,
                  conv0_phase_out_of_window, conv0_align_tripped};
   assign mode = {latch_mode_conv1_blanking, latch_mode_conv1_power,
                  latch_mode_conv0_locked, latch_mode_conv0_rotated,
                  latch_mode_conv0_window, latch_mode_conv0_tripped};

   // A write strobe aimed at one status register.
   function writeHits;
      input       strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         writeHits = strobe && (addr == target);
      end
   endfunction

   assign wrConv0 = writeHits(regWrite, regAddr, `CONV0_ALIGN_STATUS_ADDR);
   assign wrConv1 = writeHits(regWrite, regAddr, `CONV1_EVENT_STATUS_ADDR);

   // Only written ones clear; reserved positions have no strobe at all.
   assign clr = {wrConv1 & regWdata[`BIT_CONV1_BLANKING_DONE],
                 wrConv1 & regWdata[`BIT_CONV1_POWER_OVER],
                 wrConv0 & regWdata[`BIT_CONV0_ALIGN_LOCKED],
                 wrConv0 & regWdata[`BIT_CONV0_ALIGN_ROTATED],
                 wrConv0 & regWdata[`BIT_CONV0_PHASE_WINDOW],
                 wrConv0 & regWdata[`BIT_CONV0_ALIGN_TRIPPED]};

   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1)
      begin : gBit
         event_status_bit uBit
         (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .condition   (cond[i]),
            .latchMode   (mode[i]),
            .clearStrobe (clr[i]),
            .statusBit   (stat[i]),
            .latched     (held[i])
         );
      end
   endgenerate

   assign conv0Word = {4'h0, stat[3:0]} & `CONV0_ALIGN_USED_MASK;
   // Slot 4 carries the power event and slot 5 the blanking event.
   assign conv1Word = {stat[4], 1'b0, stat[5], 5'h00};

   always @*
   begin
      case (regAddr)
         `CONV0_ALIGN_STATUS_ADDR: rdata_d = conv0Word;
         `CONV1_EVENT_STATUS_ADDR: rdata_d = {conv1Word[7], 1'b0, conv1Word[5], 5'h00};
         default:                  rdata_d = 8'h00;
      endcase
   end

   // The mirrored level is sampled once into read data; no status copy is kept.
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         regRdata_q <= `STATUS_RESET_VALUE;
         irqN_q     <= 1'b1;
      end
      else
      begin
         if (regRead)
            regRdata_q <= rdata_d;
         irqN_q <= ~(|held);
      end
   end

endmodule

// File: hw/sync_power_event_map.vh
// Register offsets, bit positions and reset values for the event status block.
`ifndef SYNC_POWER_EVENT_MAP_VH
`define SYNC_POWER_EVENT_MAP_VH
`define CONV1_EVENT_STATUS_ADDR   8'h26
`define CONV0_ALIGN_STATUS_ADDR   8'h25
`define BIT_CONV0_ALIGN_LOCKED    3
`define BIT_CONV0_ALIGN_ROTATED   2
`define BIT_CONV0_PHASE_WINDOW    1
`define BIT_CONV0_ALIGN_TRIPPED   0
`define BIT_CONV1_POWER_OVER      7
`define BIT_CONV1_BLANKING_DONE   5
`define CONV0_ALIGN_USED_MASK     8'h0f
`define CONV1_EVENT_USED_MASK     8'ha0
`define STATUS_RESET_VALUE        8'h00
`endif

// File: hw/event_status_bit.v
// One status bit that either mirrors its condition or latches its rising edge.
`timescale 1ns/100ps
module event_status_bit
(
   // Clock and reset.
   input  wire ref_clk,
   input  wire rst,
   // Condition and mode.
   input  wire condition,
   input  wire latchMode,
   // Write-one-to-clear strobe.
   input  wire clearStrobe,
   // Result.
   output reg  statusBit,
   output reg  latched
);

   reg conditionPrev_q;
   reg sticky_q;
   wire riseEdge;

   assign riseEdge = condition & ~conditionPrev_q;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         conditionPrev_q <= 1'b0;
         sticky_q        <= 1'b0;
      end
      else
      begin
         conditionPrev_q <= condition;
         // A new edge in the clearing cycle wins so the event is not lost.
         if (latchMode && riseEdge)
            sticky_q <= 1'b1;
         else if (clearStrobe || !latchMode)
            sticky_q <= 1'b0;
      end
   end

   always @*
   begin
      latched   = sticky_q;
      statusBit = latchMode ? sticky_q : condition;
   end

endmodule

// File: testbench/sync_power_event_props.sv
// Checker on the event status block ports.
`timescale 1ns/100ps
module sync_power_event_props(input wire ref_clk, input wire rst, input wire [7:0] regAddr,
   input wire regWrite, input wire [7:0] regWdata, input wire regRead,
   input wire [7:0] regRdata_q, input wire conv1_power_over_threshold,
   input wire latch_mode_conv1_power, input wire irqN_q);
   wire rd = regRead && regAddr == 8'h26;
   wire pw = conv1_power_over_threshold;
   wire lm = latch_mode_conv1_power;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_mirror_read: assert property (rd && !lm |=> regRdata_q[7] == $past(pw))
      else $error("mirror");
   a_edge_irq: assert property (lm && $rose(pw) |-> ##[1:2] !irqN_q) else $error("irq");
   a_latch_holds: assert property ((lm && $rose(pw)) ##1 (lm && !regWrite)[*2] ##0 rd
      |=> regRdata_q[7]) else $error("hold");
   a_zero_keeps: assert property (!irqN_q && regWrite && regWdata == 8'h00 |=> !irqN_q)
      else $error("zero");
   a_one_clears: assert property ((regWrite && regAddr == 8'h26 && regWdata[7] && !pw)
      ##1 !pw ##1 (rd && !pw) |=> !regRdata_q[7]) else $error("clear");
   a_reserved_zero: assert property (rd |=> regRdata_q[6] == 1'b0 && regRdata_q[4] == 1'b0)
      else $error("rsvd");
   a_align_unused: assert property (regRead && regAddr == 8'h25 |=> regRdata_q[7:4] == 4'h0)
      else $error("unused");
   a_reset_clean: assert property ($fell(rst) |-> irqN_q && regRdata_q == 8'h00)
      else $error("reset");
endmodule
bind sync_power_event_status sync_power_event_props u_props(.ref_clk, .rst, .regAddr,
   .regWrite, .regWdata, .regRead, .regRdata_q, .conv1_power_over_threshold,
   .latch_mode_conv1_power, .irqN_q);

// File: testbench/host_model.sv
// Host model issuing register strobes on the falling clock edge.
`timescale 1ns/100ps
module host_model(input wire ref_clk, output reg [7:0] regAddr, output reg regWrite,
   output reg [7:0] regWdata, output reg regRead);
   initial {regAddr, regWdata, regWrite, regRead} = 18'h0;
   // One strobe cycle then release; released data is inverted so stale values never match.
   task access(input wr, input [7:0] a, input [7:0] d);
   begin
      @(negedge ref_clk) {regAddr, regWdata, regWrite, regRead} = {a, d, wr, !wr};
      @(negedge ref_clk) {regWrite, regRead, regWdata} = {2'h0, ~d};
   end
   endtask
endmodule

// File: testbench/sync_power_event_status_test.sv
// Self-checking bench for the event status block.
`timescale 1ns/100ps
module sync_power_event_status_test;
   reg        ref_clk = 1'b0;
   reg        rst = 1'b1;
   reg  [5:0] ev = 6'h00;
   reg  [5:0] md = 6'h00;
   wire [7:0] regAddr, regWdata, regRdata_q;
   wire       regWrite, regRead, irqN_q;
   integer    failures = 0;
   integer    total_checks = 0;
   integer    i;
   always #2.5 ref_clk = !ref_clk;
   host_model host(.ref_clk(ref_clk), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead));
   sync_power_event_status dut(.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
      .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead), .regRdata_q(regRdata_q),
      .irqN_q(irqN_q), .conv0_align_tripped(ev[0]), .conv0_phase_out_of_window(ev[1]),
      .conv0_align_rotated(ev[2]), .conv0_align_locked(ev[3]),
      .conv1_blanking_complete(ev[4]), .conv1_power_over_threshold(ev[5]),
      .latch_mode_conv0_tripped(md[0]), .latch_mode_conv0_window(md[1]),
      .latch_mode_conv0_rotated(md[2]), .latch_mode_conv0_locked(md[3]),
      .latch_mode_conv1_blanking(md[4]), .latch_mode_conv1_power(md[5]));
   function [7:0] adr(input integer k); adr = (k < 4) ? 8'h25 : 8'h26; endfunction
   function [7:0] msk(input integer k); msk = 8'h01 << ((k < 4) ? k : 2 * k - 3); endfunction
   task chk(input [7:0] got, input [7:0] want);
   begin
      total_checks = total_checks + 1;
      if (got !== want)
      begin
         failures = failures + 1;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   end
   endtask
   task final_report;
   begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   // The last pass reads 0x25 with every condition low and proves no converter-0 bit was stored.
   task mirror_test;
   begin
      for (i = 0; i < 7; i = i + 1)
      begin
         @(negedge ref_clk) ev = 6'h01 << i;
         host.access(1'b0, adr(i % 6), 8'h00);
         chk(regRdata_q, (i < 6) ? msk(i) : 8'h00);
         chk({7'h0, irqN_q}, 8'h01);
      end
      $display("mirror test done");
   end
   endtask
   task latch_test;
   begin
      for (i = 0; i < 6; i = i + 1)
      begin
         @(negedge ref_clk) md = 6'h01 << i;
         ev = md;
         repeat (3) @(negedge ref_clk);
         ev = 6'h00;
         chk({7'h0, irqN_q}, 8'h00);
         host.access(1'b1, adr(i), 8'h00);
         host.access(1'b0, adr(i), 8'h00);
         chk(regRdata_q, msk(i));
         host.access(1'b1, adr(i), msk(i));
         host.access(1'b0, adr(i), 8'h00);
         chk(regRdata_q, 8'h00);
         chk({7'h0, irqN_q}, 8'h01);
      end
      $display("latch test done");
   end
   endtask
   initial
   begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      chk({7'h0, irqN_q}, 8'h01);
      mirror_test;
      latch_test;
      md = 6'h3f;
      ev = 6'h3f;
      host.access(1'b1, 8'h26, 8'h50);
      host.access(1'b0, 8'h26, 8'h00);
      chk(regRdata_q, 8'ha0);
      host.access(1'b0, 8'h25, 8'h00);
      chk(regRdata_q, 8'h0f);
      $display("reserved test done");
      final_report;
   end
endmodule
